/* File: ppm_port_mux.sv */
`timescale 1ns/1ps
`include "ppm_port_regs.svh"

// Summary of operation
// R01: pull-up from dir/out/disable unless overridden
// R02: pull-up override value sets pull-up directly
// R03: driver enable from override or direction bit
// R04: direction override value forces driver on/off
// R05: driven level from value override or out
// R06: toggle override inverts the output bit
// R07: input enable from override or sleep state
// R08: input-enable override value forces buffer state
// R09: raw input taken before port synchronizer
// R10: consumers synchronize raw input unless clocking
// R11: the port mux builds override signals from peripheral controls
// R12: strobes per port, sleep/disable shared globally
// R13: pins 7,5,4,3 carry ss,sck,miso,mosi
// R14: pin 2 is timer external clock
// R15: pin 1 timer3 output, pin 0 capture
// R16: each pin n feeds pin-change source n
// R17: spi slave forces ss/sck/mosi to inputs
// R18: spi master forces miso to input
// R19: pin-change enable forces digital input on
// R20: timer3 enable overrides pin 1 value
// R21: no overrides gives plain port behaviour
module ppm_port_mux
	import ppm_pkg::*;
#(
	parameter int WIDTH = `PPM_PORT_WIDTH
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// port register strobes, shared by all pins
	input  wire logic                 dir_write_strobe,
	input  wire logic                 port_write_strobe,
	input  wire logic                 toggle_write_strobe,
	input  wire logic [WIDTH-1:0]     write_data,
	// signals shared by all ports
	input  wire logic                 sleep_clamp,
	input  wire logic                 global_pullup_disable,
	// peripheral controls and per-pin extras
	input  wire ppm_periph_type       periph,
	input  wire logic [WIDTH-1:0]     pin_change_mask,
	input  wire logic [WIDTH-1:0]     toggle_ovr_en,
	// pads
	input  wire logic [WIDTH-1:0]     pad_in,
	output logic      [WIDTH-1:0]     pad_out,
	output logic      [WIDTH-1:0]     pad_oe,
	output logic      [WIDTH-1:0]     pad_pullup,
	// register read-back and alternate inputs
	output logic      [WIDTH-1:0]     pin_dir_bit,
	output logic      [WIDTH-1:0]     pin_out_bit,
	output logic      [WIDTH-1:0]     pin_read_val,
	output logic      [WIDTH-1:0]     raw_pin_input,
	output logic      [WIDTH-1:0]     pin_change_source,
	output ppm_alt_in_type            alt_in
);

	// ****************************************
	// override table for port b
	// ****************************************

	// builds one pin's overrides from peripheral state
	function automatic ppm_ovr_type portb_ovr(input int n, input ppm_periph_type p,
			input logic out_bit, input logic pu_off, input logic pc_mask, input logic tog);
		ppm_ovr_type o;
		logic slave;
		logic master;
		o = '0;
		slave  = p.spi_enable_bit & ~p.spi_master_select;
		master = p.spi_enable_bit & p.spi_master_select;
		o.toggle_ovr_en    = tog; // R06
		o.input_en_ovr_en  = pc_mask & p.pin_change_group_enable; // R19
		o.input_en_ovr_val = 1'b1; // R19
		if (n == `PPM_PIN_SS || n == `PPM_PIN_SCK || n == `PPM_PIN_MOSI) begin
			o.pullup_ovr_en  = slave; // R17
			o.pullup_ovr_val = out_bit & ~pu_off; // R17
			o.dir_ovr_en     = slave; // R17
		end
		if (n == `PPM_PIN_MISO) begin
			o.pullup_ovr_en  = master; // R18
			o.pullup_ovr_val = out_bit & ~pu_off;
			o.dir_ovr_en     = master; // R18
			o.value_ovr_en   = slave; // R13
			o.value_ovr_val  = p.spi_slave_out;
		end
		if (n == `PPM_PIN_SCK) begin
			o.value_ovr_en  = master; // R13
			o.value_ovr_val = p.spi_sck_out;
		end
		if (n == `PPM_PIN_MOSI) begin
			o.value_ovr_en  = master; // R13
			o.value_ovr_val = p.spi_master_out;
		end
		if (n == `PPM_PIN_T3_OUT) begin
			o.value_ovr_en  = p.timer3_out_en; // R20
			o.value_ovr_val = p.timer3_mod_out; // R15
		end
		return o;
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [WIDTH-1:0] dir_q, dir_d;
	logic [WIDTH-1:0] out_q, out_d;
	logic [WIDTH-1:0] oe_q, oe_d;
	logic [WIDTH-1:0] val_q, val_d;
	logic [WIDTH-1:0] pu_q, pu_d;
	logic [WIDTH-1:0] ien_q, ien_d;
	logic [WIDTH-1:0] sync1_q;
	logic [WIDTH-1:0] sync_q;
	ppm_ovr_type      ovr [WIDTH];

	// raw input, clamped when the buffer is off, not synchronized
	assign raw_pin_input     = pad_in & ien_q; // R09
	assign pin_change_source = raw_pin_input; // R16

	// alternate-function taps; consumers synchronize these themselves
	always_comb begin
		alt_in.spi_ss_in          = raw_pin_input[`PPM_PIN_SS]; // R13
		alt_in.spi_sck_in         = raw_pin_input[`PPM_PIN_SCK]; // R13
		alt_in.spi_master_in      = raw_pin_input[`PPM_PIN_MISO]; // R13
		alt_in.spi_slave_in       = raw_pin_input[`PPM_PIN_MOSI]; // R13
		alt_in.timer_ext_clock_in = raw_pin_input[`PPM_PIN_TCLK]; // R14
		alt_in.timer3_capture_in  = raw_pin_input[`PPM_PIN_T3_CAP]; // R15
	end

	// next values of port registers and pad controls
	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		oe_d  = '0;
		val_d = '0;
		pu_d  = '0;
		ien_d = '0;
		if (dir_write_strobe)
			dir_d = write_data; // R12
		if (port_write_strobe)
			out_d = write_data; // R12
		if (toggle_write_strobe)
			out_d = out_d ^ write_data;
		for (int i = 0; i < WIDTH; i++) begin
			ovr[i] = portb_ovr(i, periph, out_q[i], global_pullup_disable,
				pin_change_mask[i], toggle_ovr_en[i]);
			if (ovr[i].toggle_ovr_en)
				out_d[i] = ~out_d[i]; // R06
			// R03 R04
			oe_d[i] = ovr[i].dir_ovr_en ? ovr[i].dir_ovr_val : dir_q[i];
			// R05 R21
			val_d[i] = ovr[i].value_ovr_en ? ovr[i].value_ovr_val : out_q[i];
			// R01 R02
			pu_d[i] = ovr[i].pullup_ovr_en ? ovr[i].pullup_ovr_val
				: (~dir_q[i] & out_q[i] & ~global_pullup_disable);
			// R07 R08
			ien_d[i] = ovr[i].input_en_ovr_en ? ovr[i].input_en_ovr_val : ~sleep_clamp;
		end
	end

	// registers; pads tri-stated in reset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dir_q   <= `PPM_DIR_RST;
			out_q   <= `PPM_OUT_RST;
			oe_q    <= `PPM_PAD_RST;
			val_q   <= `PPM_PAD_RST;
			pu_q    <= `PPM_PAD_RST;
			ien_q   <= `PPM_PAD_RST;
			sync1_q <= `PPM_SYNC_RST;
			sync_q  <= `PPM_SYNC_RST;
		end else begin
			dir_q   <= dir_d;
			out_q   <= out_d;
			oe_q    <= oe_d;
			val_q   <= val_d;
			pu_q    <= pu_d;
			ien_q   <= ien_d;
			sync1_q <= raw_pin_input; // port's own synchronizer
			sync_q  <= sync1_q;
		end
	end

	// outputs straight from flops
	assign pad_out      = val_q;
	assign pad_oe       = oe_q;
	assign pad_pullup   = pu_q;
	assign pin_dir_bit  = dir_q;
	assign pin_out_bit  = out_q;
	assign pin_read_val = sync_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic slv;
	logic mst;
	assign slv = periph.spi_enable_bit & ~periph.spi_master_select;
	assign mst = periph.spi_enable_bit & periph.spi_master_select;

	a_plain_pullup: assert property ( // R01
		!slv && !mst |=> pad_pullup[6] == ($past(~dir_q[6] & out_q[6])
			& ~$past(global_pullup_disable)))
		else $error("plain pull-up wrong on pin 6");
	a_slave_pullup: assert property ( // R02
		slv |=> pad_pullup[`PPM_PIN_SS] == ($past(out_q[`PPM_PIN_SS])
			& ~$past(global_pullup_disable)))
		else $error("slave pull-up not from output bit");
	a_slave_input: assert property ( // R17
		slv ##1 slv |=> !pad_oe[`PPM_PIN_SS] && !pad_oe[`PPM_PIN_SCK]
			&& !pad_oe[`PPM_PIN_MOSI])
		else $error("spi slave pin driven");
	a_master_miso: assert property ( // R18
		mst |=> !pad_oe[`PPM_PIN_MISO])
		else $error("miso driven in master mode");
	a_dir_follow: assert property ( // R03
		dir_write_strobe ##1 !periph.spi_enable_bit |=> pad_oe == $past(write_data, 2))
		else $error("driver enable not following direction");
	a_tmr3_value: assert property ( // R20
		periph.timer3_out_en |=> pad_out[`PPM_PIN_T3_OUT] == $past(periph.timer3_mod_out))
		else $error("timer3 output not on pin 1");
	a_toggle_inv: assert property ( // R06
		toggle_ovr_en[0] && !port_write_strobe && !toggle_write_strobe
			|=> pin_out_bit[0] != $past(pin_out_bit[0]))
		else $error("toggle override did not invert");
	a_input_en: assert property ( // R19
		pin_change_mask[2] && periph.pin_change_group_enable |=> raw_pin_input[2]
			== pad_in[2])
		else $error("pin-change input clamped");
	a_sleep_clamp: assert property ( // R07
		sleep_clamp && !pin_change_mask[5] ##1 sleep_clamp |-> raw_pin_input[5] == 1'b0)
		else $error("sleep clamp not applied");
	a_read_sync: assert property ( // R09
		ien_q[3] ##1 ien_q[3] |=> pin_read_val[3] == $past(pad_in[3], 2))
		else $error("synchronizer delay wrong");

	c_spi_slave: cover property (slv ##1 slv);
	c_spi_master: cover property (mst && pad_oe[`PPM_PIN_SCK]);
	c_tmr3_drive: cover property (periph.timer3_out_en && pad_oe[`PPM_PIN_T3_OUT]);
	c_sleep_wake: cover property (sleep_clamp ##1 !sleep_clamp);

endmodule // ppm_port_mux

/* File: ppm_port_regs.svh */
`ifndef PPM_PORT_REGS_SVH
`define PPM_PORT_REGS_SVH

// ****************************************
// port width and reset values
// ****************************************
`define PPM_PORT_WIDTH  8
`define PPM_DIR_RST     8'h00
`define PPM_OUT_RST     8'h00
`define PPM_PAD_RST     8'h00
`define PPM_SYNC_RST    8'h00

// ****************************************
// port b pin positions of alternate functions
// ****************************************
`define PPM_PIN_SS      7
`define PPM_PIN_SCK     5
`define PPM_PIN_MISO    4
`define PPM_PIN_MOSI    3
`define PPM_PIN_TCLK    2
`define PPM_PIN_T3_OUT  1
`define PPM_PIN_T3_CAP  0

`endif

/* File: ppm_pkg.sv */
package ppm_pkg;

	// ****************************************
	// per-pin override bundle
	// ****************************************
	typedef struct packed {
		logic pullup_ovr_en;
		logic pullup_ovr_val;
		logic dir_ovr_en;
		logic dir_ovr_val;
		logic value_ovr_en;
		logic value_ovr_val;
		logic toggle_ovr_en;
		logic input_en_ovr_en;
		logic input_en_ovr_val;
	} ppm_ovr_type;

	// ****************************************
	// peripheral controls that steer port b
	// ****************************************
	typedef struct packed {
		logic spi_enable_bit;
		logic spi_master_select;
		logic spi_sck_out;
		logic spi_slave_out;
		logic spi_master_out;
		logic timer3_out_en;
		logic timer3_mod_out;
		logic pin_change_group_enable;
	} ppm_periph_type;

	// ****************************************
	// alternate-function inputs taken from the pins
	// ****************************************
	typedef struct packed {
		logic spi_ss_in;
		logic spi_sck_in;
		logic spi_master_in;
		logic spi_slave_in;
		logic timer_ext_clock_in;
		logic timer3_capture_in;
	} ppm_alt_in_type;

endpackage

/* File: ppm_periph_model.sv */
`timescale 1ns/1ps
// ****
// peripheral side of port b
// ****
module ppm_periph_model
	import ppm_pkg::*;
(
	// clock and reset
	input  wire logic           clk_sys,
	input  wire logic           resetn,
	// mode: pc group, t3 level, t3 on, master, spi on
	input  wire logic [4:0]     mode_req,
	// port side
	input  wire ppm_alt_in_type alt_in,
	output ppm_periph_type      periph,
	output logic                ss_sync
);
	ppm_periph_type periph_q, periph_d;
	logic [1:0]     ss_q, ss_d;

	// peripheral controls come from mode_req; the port mux builds the overrides
	always_comb begin
		periph_d = {mode_req[0], mode_req[1], 3'h0, mode_req[2], mode_req[3],
			mode_req[4]};
		ss_d = {ss_q[0], alt_in.spi_ss_in};
	end

	// register after the edge, like real logic
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			periph_q <= '0;
			ss_q     <= 2'h0;
		end else begin
			periph_q <= periph_d;
			ss_q     <= ss_d;
		end
	end

	assign periph  = periph_q;
	assign ss_sync = ss_q[1];
endmodule // ppm_periph_model

/* File: port_pin_override_mux_tb_top.sv */
`timescale 1ns/1ps
module port_pin_override_mux_tb_top
	import ppm_pkg::*;
;
	logic clk_sys, resetn, dws, pws, tws, sleep_clamp, pu_dis, ss_sync;
	logic [7:0] wd, pc_mask, tog_en, pad_in, pad_out, pad_oe, pad_pullup;
	logic [7:0] dir_b, out_b, rd_v, raw, pcs, b;
	logic [4:0] mode_req;
	ppm_periph_type periph;
	ppm_alt_in_type alt_in;
	int err_count, total_checks;

	ppm_port_mux ppm_port_mux_i (.clk_sys(clk_sys), .resetn(resetn),
		.dir_write_strobe(dws), .port_write_strobe(pws),
		.toggle_write_strobe(tws), .write_data(wd), .sleep_clamp(sleep_clamp),
		.global_pullup_disable(pu_dis), .periph(periph), .pin_change_mask(pc_mask),
		.toggle_ovr_en(tog_en), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pullup(pad_pullup), .pin_dir_bit(dir_b),
		.pin_out_bit(out_b), .pin_read_val(rd_v), .raw_pin_input(raw),
		.pin_change_source(pcs), .alt_in(alt_in));
	ppm_periph_model ppm_periph_model_i (.clk_sys(clk_sys), .resetn(resetn),
		.mode_req(mode_req), .alt_in(alt_in), .periph(periph), .ss_sync(ss_sync));

	// ****
	// shared tasks
	// ****
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (3) @(negedge clk_sys);
	endtask

	// load direction then output bits over two cycles, or toggle output bits when t is set
	task automatic wr(input logic [7:0] d, input logic [7:0] o, input logic t);
		wd  = t ? o : d;
		dws = !t;
		tws = t;
		@(negedge clk_sys);
		wd  = o;
		dws = 1'b0;
		tws = 1'b0;
		pws = !t;
		@(negedge clk_sys);
		pws = 1'b0;
		settle();
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_plain();
		wr(8'h0f, 8'h55, 1'b0);
		pad_in = 8'ha5;
		settle();
		chk("oe", pad_oe, 8'h0f);
		chk("dir", dir_b, 8'h0f);
		chk("pu", pad_pullup, 8'h50);
		chk("out", pad_out & pad_oe, 8'h05);
		chk("raw", raw, 8'ha5);
		chk("pcs", pcs, 8'ha5);
		chk("alt", {2'h0, alt_in}, 8'h33);
		chk("rd", rd_v, 8'ha5);
		chk("ss", {7'h0, ss_sync}, 8'h01);
		pu_dis = 1'b1;
		settle();
		chk("pu_off", pad_pullup, 8'h00);
		pu_dis = 1'b0;
	endtask

	task automatic t_toggle();
		wr(8'h0f, 8'hf0, 1'b1);
		chk("tog", out_b, 8'ha5);
		tog_en = 8'h01;
		@(negedge clk_sys);
		b = out_b;
		@(negedge clk_sys);
		chk("tog_ovr", {7'h0, out_b[0]}, {7'h0, ~b[0]});
		tog_en = 8'h00;
	endtask

	task automatic t_spi();
		wr(8'hff, 8'hff, 1'b0);
		mode_req = 5'h01;
		settle();
		chk("s_oe", pad_oe, 8'h57);
		chk("s_pu", pad_pullup, 8'ha8);
		chk("s_out", pad_out & pad_oe, 8'h47);
		mode_req = 5'h03;
		settle();
		chk("m_oe", pad_oe, 8'hef);
		chk("m_pu", pad_pullup, 8'h10);
		chk("m_out", pad_out & pad_oe, 8'hc7);
		mode_req = 5'h04;
		settle();
		chk("t3", pad_out & pad_oe, 8'hfd);
		mode_req = 5'h0c;
		settle();
		chk("t3_hi", pad_out & pad_oe, 8'hff);
	endtask

	task automatic t_sleep();
		mode_req = 5'h00;
		wr(8'h00, 8'h00, 1'b0);
		pad_in = 8'hff;
		sleep_clamp = 1'b1;
		settle();
		chk("clamp", raw, 8'h00);
		pc_mask = 8'h0f;
		mode_req = 5'h10;
		settle();
		chk("die_ovr", raw, 8'h0f);
		sleep_clamp = 1'b0;
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		{dws, pws, tws, sleep_clamp, pu_dis, resetn} = 6'h00;
		{wd, pc_mask, tog_en, pad_in} = 32'h0;
		mode_req = 5'h00;
		err_count = 0;
		total_checks = 0;
		repeat (5) @(negedge clk_sys);
		chk("rst", pad_oe | pad_pullup | raw, 8'h00);
		repeat (5) @(negedge clk_sys);
		resetn = 1'b1;
		t_plain();
		t_toggle();
		t_spi();
		t_sleep();
		end_of_test();
	end
endmodule // port_pin_override_mux_tb_top
